/* core/tar_pkg.sv */
// Package of constants for the trip auto-restart controller
package tar_pkg;
    // Clock and tick timing
    localparam int CLK_HZ = 50000000;
    localparam int TICK_MS = 100;
    localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
    // Trip-free period that clears the attempt record, in ticks of 0.1 s
    localparam int CLEAN_MIN_S = 300;
    localparam logic [15:0] CLEAN_MIN_TICKS = 16'(CLEAN_MIN_S * 10);
    localparam int CLEAN_MULT = 4;
    // Setting ranges and defaults, delays in tenths of a second
    localparam logic [3:0] LIMIT_MIN = 4'h1;
    localparam logic [3:0] LIMIT_MAX = 4'ha;
    localparam logic [3:0] LIMIT_RST = 4'h5;
    localparam logic [12:0] WAIT_MAX = 13'h1770;
    localparam logic [12:0] WAIT_A_RST = 13'h0064;
    localparam logic [12:0] WAIT_B_RST = 13'h0001;
    localparam logic [15:0] MASK_RST = 16'h0000;
    // APB register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_LIMIT = 8'h04;
    localparam logic [7:0] OFS_FIRST_A = 8'h08;
    localparam logic [7:0] OFS_RETRY_A = 8'h0c;
    localparam logic [7:0] OFS_MASK_A = 8'h10;
    localparam logic [7:0] OFS_FIRST_B = 8'h14;
    localparam logic [7:0] OFS_RETRY_B = 8'h18;
    localparam logic [7:0] OFS_MASK_B = 8'h1c;
    localparam logic [7:0] OFS_STATUS = 8'h20;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h24;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h28;
    // Status word fields
    localparam int ST_WAIT_BIT = 0;
    localparam int ST_ACT_BIT = 1;
    localparam int ST_LEFT_LSB = 4;
    localparam int ST_TIME_LSB = 16;
    // Interrupt events
    localparam int IRQ_W = 3;
    localparam int EV_SCHED = 0;
    localparam int EV_RESTART = 1;
    localparam int EV_EXHAUST = 2;
    typedef enum logic [1:0] {
        TAR_IDLE, TAR_HOLD, TAR_TIMING, TAR_RESTART
    } tar_state_t;
endpackage

/* core/tar_ctrl.sv */
// Trip auto-restart controller with APB registers
////////////////////////////////////////////////////////////////////////////
// What this block does
// - Auto reset and restart only when enabled
// - Restart attempts limited to 1..10, default 5
// - Attempts cleared by manual reset or trip-free run
// - No auto restart in remote comms sequencing
// - Group A first delay, from errors clearing
// - Group A retry delay between later attempts
// - Group B first delay, default 0.1 s
// - Group B retry delay from errors clearing
// - Two 16-bit trip masks, reset to zero
// - Trip in both masks uses group A delays
// - Waiting flag while restart is scheduled
// - Active flag while restart is carried out
// - Report attempts still available
// - Report remaining wait in 0.1 s steps
// - Loaded countdown ignores later delay changes
module tar_ctrl
    import tar_pkg::*;
#(
    parameter int TICK_DIV = TICK_CYCLES
) (
    // Clock, reset, enable
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic ce_in,
    // APB slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // Drive trip detection and sequencing
    input wire logic trip_in,
    input wire logic [3:0] trip_code_in,
    input wire logic errors_clear_in,
    input wire logic running_in,
    input wire logic ext_reset_in,
    input wire logic comms_seq_in,
    output logic trip_reset_out,
    output logic restart_req_out,
    // Status and interrupt
    output logic restart_waiting_out,
    output logic restart_active_out,
    output logic [3:0] retries_remaining_out,
    output logic [12:0] wait_remaining_out,
    output logic irq_out
);
    ////////////////////////////////////////////////////////////////////////
    // Registers
    logic auto_recover_on_ff;
    logic [3:0] restart_limit_ff;
    logic [12:0] first_wait_a_ff, retry_wait_a_ff;
    logic [12:0] first_wait_b_ff, retry_wait_b_ff;
    logic [15:0] trip_mask_a_ff, trip_mask_b_ff;
    logic [IRQ_W-1:0] irq_stat_ff, irq_mask_ff;
    tar_state_t state_ff;
    logic [3:0] used_ff;
    logic [12:0] remain_ff;
    logic [31:0] tick_cnt_ff;
    logic [15:0] clean_cnt_ff;
    logic group_b_ff;

    ////////////////////////////////////////////////////////////////////////
    // APB decode
    wire apb_setup = psel_in && !penable_in;
    wire apb_wr = psel_in && penable_in && pwrite_in && ce_in;
    wire apb_rd = psel_in && penable_in && !pwrite_in && ce_in;
    wire hit_ctrl = paddr_in == OFS_CTRL;
    wire hit_limit = paddr_in == OFS_LIMIT;
    wire hit_fa = paddr_in == OFS_FIRST_A;
    wire hit_ra = paddr_in == OFS_RETRY_A;
    wire hit_ma = paddr_in == OFS_MASK_A;
    wire hit_fb = paddr_in == OFS_FIRST_B;
    wire hit_rb = paddr_in == OFS_RETRY_B;
    wire hit_mb = paddr_in == OFS_MASK_B;
    wire hit_st = paddr_in == OFS_STATUS;
    wire hit_is = paddr_in == OFS_IRQ_STAT;
    wire hit_im = paddr_in == OFS_IRQ_MASK;
    wire mapped = hit_ctrl | hit_limit | hit_fa | hit_ra | hit_ma | hit_fb
        | hit_rb | hit_mb | hit_st | hit_is | hit_im;
    wire [3:0] limit_in = pwdata_in[3:0];
    // Out-of-range settings are clamped rather than refused
    wire [3:0] limit_clamped = (limit_in < LIMIT_MIN) ? LIMIT_MIN :
        (limit_in > LIMIT_MAX) ? LIMIT_MAX : limit_in;
    wire [12:0] wdly = (pwdata_in[12:0] > WAIT_MAX) ? WAIT_MAX
        : pwdata_in[12:0];

    wire [3:0] left = (used_ff >= restart_limit_ff) ? 4'h0
        : restart_limit_ff - used_ff;
    wire [31:0] status_word = {3'h0, remain_ff, 8'h00, left, 2'h0,
        restart_active_out, restart_waiting_out};
    wire [31:0] rd_mux =
        hit_ctrl ? {31'h0, auto_recover_on_ff} :
        hit_limit ? {28'h0, restart_limit_ff} :
        hit_fa ? {19'h0, first_wait_a_ff} :
        hit_ra ? {19'h0, retry_wait_a_ff} :
        hit_ma ? {16'h0, trip_mask_a_ff} :
        hit_fb ? {19'h0, first_wait_b_ff} :
        hit_rb ? {19'h0, retry_wait_b_ff} :
        hit_mb ? {16'h0, trip_mask_b_ff} :
        hit_st ? status_word :
        hit_is ? {29'h0, irq_stat_ff} :
        hit_im ? {29'h0, irq_mask_ff} : 32'h0;

    // No wait state: ready answers in the first access cycle
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            pready_out <= 1'b0;
            pslverr_out <= 1'b0;
            prdata_out <= 32'h0;
        end else if (ce_in) begin
            pready_out <= apb_setup;
            // Misaligned offsets never decode, so they answer as unmapped
            pslverr_out <= apb_setup && !mapped;
            if (apb_setup && !pwrite_in) begin
                prdata_out <= rd_mux;
            end
        end
    end

    wire acc_done = pready_out;
    wire wr_go = apb_wr && acc_done;
    wire rd_is_go = apb_rd && acc_done && hit_is;

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            auto_recover_on_ff <= 1'b0;
            restart_limit_ff <= LIMIT_RST;
            first_wait_a_ff <= WAIT_A_RST;
            retry_wait_a_ff <= WAIT_A_RST;
            first_wait_b_ff <= WAIT_B_RST;
            retry_wait_b_ff <= WAIT_B_RST;
            trip_mask_a_ff <= MASK_RST;
            trip_mask_b_ff <= MASK_RST;
            irq_mask_ff <= '0;
        end else if (wr_go) begin
            if (hit_ctrl) auto_recover_on_ff <= pwdata_in[0];
            if (hit_limit) restart_limit_ff <= limit_clamped;
            if (hit_fa) first_wait_a_ff <= wdly;
            if (hit_ra) retry_wait_a_ff <= wdly;
            if (hit_ma) trip_mask_a_ff <= pwdata_in[15:0];
            if (hit_fb) first_wait_b_ff <= wdly;
            if (hit_rb) retry_wait_b_ff <= wdly;
            if (hit_mb) trip_mask_b_ff <= pwdata_in[15:0];
            if (hit_im) irq_mask_ff <= pwdata_in[IRQ_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Tick prescaler
    wire tick = ce_in && (tick_cnt_ff == 32'(TICK_DIV - 1));
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            tick_cnt_ff <= 32'h0;
        end else if (ce_in) begin
            tick_cnt_ff <= tick ? 32'h0 : tick_cnt_ff + 32'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Restart sequencer
    wire sel_a = trip_mask_a_ff[trip_code_in];
    wire sel_b = trip_mask_b_ff[trip_code_in];
    wire allowed = auto_recover_on_ff && !comms_seq_in;
    wire exhausted = used_ff >= restart_limit_ff;
    wire trip_take = trip_in && (sel_a || sel_b) && allowed && !exhausted;
    // Group A wins when both masks select the trip
    wire use_b = !sel_a;
    wire first_try = used_ff == 4'h0;
    wire [12:0] dly_a = first_try ? first_wait_a_ff : retry_wait_a_ff;
    wire [12:0] dly_b = first_try ? first_wait_b_ff : retry_wait_b_ff;
    wire [12:0] dly_pick = group_b_ff ? dly_b : dly_a;
    wire expire = state_ff == TAR_TIMING && remain_ff == 13'h0;
    // Trip-free limit: the longer of five minutes and 4x retry A
    wire [15:0] four_ra = {retry_wait_a_ff, 2'b00} + 16'h0 ;
    wire [15:0] clean_lim = (four_ra > CLEAN_MIN_TICKS) ? four_ra
        : CLEAN_MIN_TICKS;
    wire clean_done = clean_cnt_ff >= clean_lim;

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            state_ff <= TAR_IDLE;
            remain_ff <= 13'h0;
            group_b_ff <= 1'b0;
            trip_reset_out <= 1'b0;
            restart_req_out <= 1'b0;
        end else if (ce_in) begin
            trip_reset_out <= 1'b0;
            restart_req_out <= 1'b0;
            unique case (state_ff)
                TAR_IDLE: begin
                    if (trip_take) begin
                        group_b_ff <= use_b;
                        state_ff <= TAR_HOLD;
                    end
                end
                TAR_HOLD: begin
                    if (!allowed || ext_reset_in) begin
                        state_ff <= TAR_IDLE;
                    end else if (errors_clear_in) begin
                        remain_ff <= dly_pick;
                        state_ff <= TAR_TIMING;
                    end
                end
                TAR_TIMING: begin
                    if (!allowed || ext_reset_in) begin
                        remain_ff <= 13'h0;
                        state_ff <= TAR_IDLE;
                    end else if (expire) begin
                        trip_reset_out <= 1'b1;
                        state_ff <= TAR_RESTART;
                    end else if (tick) begin
                        remain_ff <= remain_ff - 13'h1;
                    end
                end
                TAR_RESTART: begin
                    // A mode change after the reset pulse still blocks start
                    if (allowed) begin
                        restart_req_out <= 1'b1;
                    end
                    state_ff <= TAR_IDLE;
                end
            endcase
        end
    end

    // Attempt record and trip-free timer
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            used_ff <= 4'h0;
            clean_cnt_ff <= 16'h0;
        end else if (ce_in) begin
            if (ext_reset_in) begin
                used_ff <= 4'h0;
            end else if (state_ff == TAR_RESTART) begin
                used_ff <= used_ff + 4'h1;
            end else if (clean_done) begin
                used_ff <= 4'h0;
            end
            if (trip_in || !running_in || clean_done) begin
                clean_cnt_ff <= 16'h0;
            end else if (tick) begin
                clean_cnt_ff <= clean_cnt_ff + 16'h1;
            end
        end
    end

    // Status outputs come from flops
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            restart_waiting_out <= 1'b0;
            restart_active_out <= 1'b0;
            retries_remaining_out <= LIMIT_RST;
            wait_remaining_out <= 13'h0;
        end else if (ce_in) begin
            restart_waiting_out <= state_ff == TAR_HOLD
                || (state_ff == TAR_TIMING && !expire);
            restart_active_out <= (state_ff == TAR_TIMING && expire)
                || state_ff == TAR_RESTART;
            retries_remaining_out <= left;
            wait_remaining_out <= remain_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupts: set beats the clear-on-read
    wire [IRQ_W-1:0] ev;
    assign ev[EV_SCHED] = ce_in && state_ff == TAR_IDLE && trip_take;
    assign ev[EV_RESTART] = ce_in && state_ff == TAR_RESTART;
    assign ev[EV_EXHAUST] = ce_in && trip_in && allowed && exhausted
        && (sel_a || sel_b);
    // Clear only the bits the read returned: an event that lands between
    // the setup and the access cycle is kept for the next read
    wire [IRQ_W-1:0] irq_clr = rd_is_go ? prdata_out[IRQ_W-1:0] : '0;
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            irq_stat_ff <= '0;
            irq_out <= 1'b0;
        end else begin
            irq_stat_ff <= (irq_stat_ff & ~irq_clr) | ev;
            if (ce_in) begin
                irq_out <= |(irq_stat_ff & irq_mask_ff);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    property p_dis;
        @(posedge clk_in) disable iff (rst_in)
        (ce_in && (!auto_recover_on_ff || comms_seq_in))
            |=> !restart_req_out;
    endproperty
    a_dis: assert property (p_dis)
        else $error("restart while disabled or in comms mode");
    sequence s_expire;
        ce_in && expire && allowed && !ext_reset_in;
    endsequence
    property p_seq;
        @(posedge clk_in) disable iff (rst_in)
        s_expire |=> trip_reset_out;
    endproperty
    a_seq: assert property (p_seq)
        else $error("no trip reset after expiry");
    property p_pulse;
        @(posedge clk_in) disable iff (rst_in)
        (ce_in && trip_reset_out) |=> !trip_reset_out;
    endproperty
    a_pulse: assert property (p_pulse)
        else $error("trip reset pulse too long");
    property p_req;
        @(posedge clk_in) disable iff (rst_in)
        (ce_in && state_ff == TAR_RESTART && allowed) |=> restart_req_out;
    endproperty
    a_req: assert property (p_req)
        else $error("no restart request");
    property p_lim;
        @(posedge clk_in) disable iff (rst_in)
        restart_limit_ff >= LIMIT_MIN && restart_limit_ff <= LIMIT_MAX;
    endproperty
    a_lim: assert property (p_lim)
        else $error("restart limit out of range");
    property p_exh;
        @(posedge clk_in) disable iff (rst_in)
        (ce_in && state_ff == TAR_IDLE && exhausted)
            |=> state_ff == TAR_IDLE;
    endproperty
    a_exh: assert property (p_exh)
        else $error("trip taken with no attempts left");
    property p_load;
        @(posedge clk_in) disable iff (rst_in)
        (ce_in && state_ff == TAR_HOLD && allowed && !ext_reset_in
            && errors_clear_in) |=> remain_ff == $past(dly_pick);
    endproperty
    a_load: assert property (p_load)
        else $error("wrong delay loaded");
    property p_hold;
        @(posedge clk_in) disable iff (rst_in)
        (state_ff == TAR_TIMING && !tick && !expire && allowed
            && !ext_reset_in) |=> $stable(remain_ff);
    endproperty
    a_hold: assert property (p_hold)
        else $error("countdown moved off tick");
    property p_tick;
        @(posedge clk_in) disable iff (rst_in)
        (ce_in && state_ff == TAR_TIMING && tick && !expire && allowed
            && !ext_reset_in) |=> remain_ff == $past(remain_ff) - 13'h1;
    endproperty
    a_tick: assert property (p_tick)
        else $error("countdown missed a tick");
    property p_clr;
        @(posedge clk_in) disable iff (rst_in)
        (ce_in && ext_reset_in) |=> used_ff == 4'h0;
    endproperty
    a_clr: assert property (p_clr)
        else $error("attempts not cleared");
    property p_prio;
        @(posedge clk_in) disable iff (rst_in)
        (ce_in && state_ff == TAR_IDLE && trip_take && sel_a)
            |=> !group_b_ff;
    endproperty
    a_prio: assert property (p_prio)
        else $error("group A not preferred");
    property p_wait;
        @(posedge clk_in) disable iff (rst_in)
        (ce_in && state_ff == TAR_HOLD) |=> restart_waiting_out;
    endproperty
    a_wait: assert property (p_wait)
        else $error("waiting flag missing");
    property p_act;
        @(posedge clk_in) disable iff (rst_in)
        (ce_in && state_ff == TAR_RESTART) |=> restart_active_out;
    endproperty
    a_act: assert property (p_act)
        else $error("active flag missing");
endmodule

/* test/tar_drive_model.sv */
// Behavioural model of the drive's trip detection and sequencing logic
module tar_drive_model (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Bench commands
    input wire logic go_in,
    input wire logic [3:0] code_in,
    // From the controller and the operator
    input wire logic trip_reset_in,
    input wire logic restart_req_in,
    input wire logic ext_reset_in,
    // To the controller
    output logic trip_out,
    output logic [3:0] trip_code_out,
    output logic errors_clear_out,
    output logic running_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] clr_cnt_ff;
    // Error conditions linger a few cycles after a trip, as a real fault does
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            trip_out <= 1'b0;
            trip_code_out <= 4'h0;
            errors_clear_out <= 1'b1;
            running_out <= 1'b0;
            clr_cnt_ff <= 3'h0;
        end else if (go_in) begin
            trip_out <= 1'b1;
            trip_code_out <= code_in;
            errors_clear_out <= 1'b0;
            running_out <= 1'b0;
            clr_cnt_ff <= 3'h4;
        end else begin
            if (clr_cnt_ff != 3'h0) begin
                clr_cnt_ff <= clr_cnt_ff - 3'h1;
            end else begin
                errors_clear_out <= 1'b1;
            end
            if (trip_reset_in || ext_reset_in) begin
                trip_out <= 1'b0;
            end
            if (restart_req_in) begin
                running_out <= 1'b1;
            end
        end
    end
endmodule

/* test/tar_ctrl_tb_top.sv */
// Self-checking testbench of the trip auto-restart controller
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin \
 n_mismatch++; $display("wrong value %s exp %0h got %0h", nm, e, g); end end
module tar_ctrl_tb_top;
    import tar_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TICK = 10;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata_out, rd;
    logic pready_out, pslverr_out, err;
    logic go = 1'b0, ext_reset = 1'b0, comms_seq = 1'b0, ce = 1'b1;
    logic [3:0] code = 4'h0, trip_code, retries_remaining_out;
    logic trip, errors_clear, running, trip_reset_out, restart_req_out;
    logic restart_waiting_out, restart_active_out, irq_out;
    logic [12:0] wait_remaining_out;
    int n_mismatch = 0, num_checks = 0, cyc = 0;
    localparam logic [7:0] RA [8] = '{OFS_CTRL, OFS_LIMIT, OFS_FIRST_A,
        OFS_RETRY_A, OFS_MASK_A, OFS_FIRST_B, OFS_RETRY_B, OFS_MASK_B};
    localparam logic [31:0] RV [8] = '{32'h0, 32'h5, 32'h64, 32'h64,
        32'h0, 32'h1, 32'h1, 32'h0};
    tar_ctrl #(.TICK_DIV(TICK)) i_tar_ctrl (.clk_in(clk_in), .rst_in(rst_in),
        .ce_in(ce), .psel_in(psel), .penable_in(penable),
        .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
        .prdata_out(prdata_out), .pready_out(pready_out),
        .pslverr_out(pslverr_out), .trip_in(trip), .trip_code_in(trip_code),
        .errors_clear_in(errors_clear), .running_in(running),
        .ext_reset_in(ext_reset), .comms_seq_in(comms_seq),
        .trip_reset_out(trip_reset_out), .restart_req_out(restart_req_out),
        .restart_waiting_out(restart_waiting_out),
        .restart_active_out(restart_active_out),
        .retries_remaining_out(retries_remaining_out),
        .wait_remaining_out(wait_remaining_out), .irq_out(irq_out));
    tar_drive_model i_tar_drive_model (.clk_in(clk_in), .rst_in(rst_in),
        .go_in(go), .code_in(code), .trip_reset_in(trip_reset_out),
        .restart_req_in(restart_req_out), .ext_reset_in(ext_reset),
        .trip_out(trip), .trip_code_out(trip_code),
        .errors_clear_out(errors_clear), .running_out(running));
    initial begin
        forever #10 clk_in = ~clk_in;
    end
    ////////////////////////////////////////////////////////////////////////
    // Every task is entered just after a rising edge; all but stop_test leave after one
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_in);
        penable <= 1'b1;
        // Only the bench timeout ends a wait for ready
        do begin
            @(posedge clk_in);
        end while (pready_out !== 1'b1);
        rd = prdata_out;
        err = pslverr_out;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_in);
    endtask
    task automatic ext_rst();
        ext_reset <= 1'b1;
        @(posedge clk_in);
        ext_reset <= 1'b0;
        repeat (3) @(posedge clk_in);
    endtask
    task automatic trip_go(input logic [3:0] c);
        go <= 1'b1;
        code <= c;
        @(posedge clk_in);
        go <= 1'b0;
    endtask
    // A trip that must not be taken; the operator reset then clears it
    task automatic no_take(input logic [3:0] c);
        trip_go(c);
        repeat (15) @(posedge clk_in);
        `CHK("waiting", 1'b0, restart_waiting_out);
        ext_rst();
    endtask
    task automatic run_trip(input logic [3:0] c, input logic [12:0] w,
                            input logic [3:0] left, input logic [12:0] nw);
        int i;
        logic [12:0] v;
        trip_go(c);
        i = 0;
        while (restart_waiting_out !== 1'b1 && i < 20) begin
            @(posedge clk_in);
            i++;
        end
        `CHK("waiting", 1'b1, restart_waiting_out);
        i = 0;
        while (wait_remaining_out === 13'h0 && i < 20) begin
            @(posedge clk_in);
            i++;
        end
        `CHK("loaded wait", w, wait_remaining_out);
        // Clock enable low must freeze the countdown and the flags
        ce <= 1'b0;
        @(posedge clk_in);
        v = wait_remaining_out;
        repeat (20) @(posedge clk_in);
        `CHK("frozen wait", v, wait_remaining_out);
        `CHK("frozen flag", 1'b1, restart_waiting_out);
        ce <= 1'b1;
        // A setting change in mid-countdown must not stretch the wait
        if (nw != 13'h0) apb(1'b1, OFS_RETRY_A, 32'(nw));
        i = 0;
        while (trip_reset_out !== 1'b1 && i < int'(w) * TICK + 40) begin
            @(posedge clk_in);
            i++;
        end
        `CHK("tick paced", 1'b1, i >= (int'(w) - 1) * TICK - 10);
        `CHK("reset pulse", 1'b1, trip_reset_out);
        `CHK("active", 1'b1, restart_active_out);
        @(posedge clk_in);
        `CHK("restart req", 1'b1, restart_req_out);
        `CHK("pulse width", 1'b0, trip_reset_out);
        repeat (3) @(posedge clk_in);
        `CHK("retries left", left, retries_remaining_out);
        `CHK("flags idle", 2'b00, {restart_waiting_out, restart_active_out});
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    always @(posedge clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            n_mismatch++;
            stop_test();
        end
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (3) @(posedge clk_in);
        rst_in <= 1'b0;
        @(posedge clk_in);
        `CHK("flags", 2'b00, {restart_waiting_out, restart_active_out});
        for (int k = 0; k < 8; k++) begin
            apb(1'b0, RA[k], 32'h0);
            `CHK("reset value", RV[k], rd);
        end
        apb(1'b0, OFS_STATUS, 32'h0);
        `CHK("status", 32'h50, rd);
        apb(1'b0, 8'h2c, 32'h0);
        `CHK("unmapped", 33'h100000000, {err, rd});
        apb(1'b1, OFS_LIMIT, 32'h0);
        apb(1'b0, OFS_LIMIT, 32'h0);
        `CHK("limit low", 32'h1, rd);
        apb(1'b1, OFS_LIMIT, 32'hf);
        apb(1'b0, OFS_LIMIT, 32'h0);
        `CHK("limit high", 32'ha, rd);
        apb(1'b1, OFS_LIMIT, 32'h5);
        apb(1'b1, OFS_MASK_A, 32'h0008);
        no_take(4'h3);
        apb(1'b1, OFS_CTRL, 32'h1);
        comms_seq <= 1'b1;
        no_take(4'h3);
        comms_seq <= 1'b0;
        apb(1'b1, OFS_FIRST_A, 32'h2);
        apb(1'b1, OFS_RETRY_A, 32'h3);
        apb(1'b1, OFS_IRQ_MASK, 32'h2);
        run_trip(4'h3, 13'h2, 4'h4, 13'h0);
        `CHK("irq line", 1'b1, irq_out);
        apb(1'b0, OFS_IRQ_STAT, 32'h0);
        `CHK("irq status", 32'h3, rd);
        apb(1'b0, OFS_IRQ_STAT, 32'h0);
        `CHK("irq cleared", 32'h0, rd);
        `CHK("irq low", 1'b0, irq_out);
        run_trip(4'h3, 13'h3, 4'h3, 13'h28);
        ext_rst();
        `CHK("record cleared", 4'h5, retries_remaining_out);
        apb(1'b1, OFS_MASK_B, 32'h0020);
        apb(1'b1, OFS_FIRST_B, 32'h4);
        apb(1'b1, OFS_RETRY_B, 32'h6);
        run_trip(4'h5, 13'h4, 4'h4, 13'h0);
        run_trip(4'h5, 13'h6, 4'h3, 13'h0);
        apb(1'b1, OFS_MASK_A, 32'h0028);
        ext_rst();
        run_trip(4'h5, 13'h2, 4'h4, 13'h0);
        apb(1'b1, OFS_LIMIT, 32'h1);
        ext_rst();
        run_trip(4'h3, 13'h2, 4'h0, 13'h0);
        no_take(4'h3);
        stop_test();
    end
endmodule
